// [inc/ccrz_pkg.sv]
// Purpose: constants and types for converter control register zero
// Assumes: 10 MHz module clock, AXI4-Lite register access
// Notes:   rule summary below
// Operation
// - Bit 15 powers the converter and gates which fields may be written.
// - Clearing enable aborts the running sequence and discards all results.
// - No re-enable until pending work has drained, within a bounded latency.
// - After enable, wait the recovery period before the first conversion.
// - Writing one to bit 14 starts a converter soft reset.
// - Soft reset clears overrun and error flags and idles the engine.
// - Soft reset zeroes command and result indices and list selects.
// - A severe error stops the converter until software soft-resets it.
// - Soft-reset bit ignores writes once set; hardware clears it when done.
// - Bit 13 set: conversion stops at next boundary in freeze mode.
// - Bit 12 set: conversion halts at next boundary in wait mode.
// - Enable, soft-reset, freeze, wait bits writable anytime; all readable.
// - Mode, abort-store, access path writable only if disabled or special.
// - Bits 11:10 pick internal, bus or both paths to flow control register.
// - Access path 00 none, 01 internal, 10 bus, 11 both.

package ccrz_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W   = 4;
  localparam logic [3:0]  OFF_CTL0 = 4'h0;
  localparam logic [3:0]  OFF_AUX  = 4'h4;
  localparam logic [3:0]  OFF_STS  = 4'h8;
  localparam logic [15:0] CTL0_RST = 16'h0000;

  localparam int EN_BIT   = 15;
  localparam int SR_BIT   = 14;
  localparam int FRZ_BIT  = 13;
  localparam int WAI_BIT  = 12;
  localparam int ACC_LSB  = 10;
  localparam int STR_BIT  = 9;
  localparam int MOD_BIT  = 8;
  localparam int SMOD_BIT = 0;
  localparam int STS_W    = 8;

  localparam logic [1:0] SEL_CTL  = 2'h0;
  localparam logic [1:0] SEL_AUX  = 2'h1;
  localparam logic [1:0] SEL_STS  = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_NS      = 100;
  localparam int T_REC_NS    = 1000;
  localparam int T_DIS_NS    = 500;
  localparam int REC_CYC     = (T_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIS_CYC     = (T_DIS_NS / CLK_NS < 1) ? 1 : T_DIS_NS / CLK_NS;
  localparam int SRST_CYC    = 4;
  localparam int TMR_W       = 8;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic       en;
    logic       sr;
    logic       frz;
    logic       wai;
    logic [1:0] acc;
    logic       str;
    logic       mode;
    logic [7:0] rsvd;
  } ccrz_ctl_s;

  typedef struct packed {
    logic int_path;
    logic bus_path;
    logic flow_mode;
    logic store_abort;
  } ccrz_flow_s;

  typedef enum logic [2:0] {
    S_OFF, S_RECOVER, S_READY, S_BUSY, S_DRAIN, S_SRST, S_ERROR
  } ccrz_state_e;

endpackage

// [src/ccrz_timer.sv]
// Purpose: loadable down counter for recovery, drain and reset waits
// Assumes: load has priority over counting
// Notes:   zero is high whenever the count has run out

`timescale 1ns/1ps
`default_nettype none

module ccrz_timer #(
  parameter int W = 8
) (
  input  wire logic         clk,     // module clock
  input  wire logic         rst_n,   // async reset, low
  input  wire logic         load,    // load val this edge
  input  wire logic [W-1:0] val,     // cycles to wait
  output logic              zero     // count expired
);

  generate
    if (W < 1 || W > 16) begin : g_chk
      $error("ccrz_timer: W out of range");
    end
  endgenerate

  logic [W-1:0] cnt_q;

  assign zero = (cnt_q == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= val;
    end else if (!zero) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

endmodule

`default_nettype wire

// [src/ccrz_top.sv]
// Purpose: converter control register zero with enable/reset sequencing
// Assumes: engine reports boundaries on CONV_DONE, errors on SEVERE_ERR
// Notes:   register word at 0x0, aux at 0x4, status at 0x8
//
// Local design decision: the AXI4-Lite interface to the registers.

`timescale 1ns/1ps
`default_nettype none

module ccrz_top #(
  parameter int REC_CYC  = ccrz_pkg::REC_CYC,
  parameter int DIS_CYC  = ccrz_pkg::DIS_CYC,
  parameter int SRST_CYC = ccrz_pkg::SRST_CYC
) (
  input  wire logic                       MCLK,          // module clock
  input  wire logic                       RST_N,         // async reset, low
  input  wire logic [ccrz_pkg::ADDR_W-1:0] S_AXI_AWADDR, // write address
  input  wire logic                       S_AXI_AWVALID, // write addr valid
  output logic                            S_AXI_AWREADY, // write addr ready
  input  wire logic [31:0]                S_AXI_WDATA,   // write data
  input  wire logic [3:0]                 S_AXI_WSTRB,   // byte enables
  input  wire logic                       S_AXI_WVALID,  // write data valid
  output logic                            S_AXI_WREADY,  // write data ready
  output logic [1:0]                      S_AXI_BRESP,   // write response
  output logic                            S_AXI_BVALID,  // response valid
  input  wire logic                       S_AXI_BREADY,  // response ready
  input  wire logic [ccrz_pkg::ADDR_W-1:0] S_AXI_ARADDR, // read address
  input  wire logic                       S_AXI_ARVALID, // read addr valid
  output logic                            S_AXI_ARREADY, // read addr ready
  output logic [31:0]                     S_AXI_RDATA,   // read data
  output logic [1:0]                      S_AXI_RRESP,   // read response
  output logic                            S_AXI_RVALID,  // read data valid
  input  wire logic                       S_AXI_RREADY,  // read data ready
  input  wire logic                       TRIG,          // launch request
  input  wire logic                       CONV_DONE,     // conversion boundary
  input  wire logic                       FREEZE_MODE,   // freeze mode active
  input  wire logic                       WAIT_MODE,     // wait mode active
  input  wire logic                       SEVERE_ERR,    // severe error pulse
  output logic                            ANALOG_EN,     // analog power on
  output logic                            CONV_START,    // start pulse
  output logic                            CONV_ABORT,    // abort, discard
  output logic                            CONV_HALT,     // held at boundary
  output logic                            SRST_CLEAR,    // clear flags/indices
  output logic                            CEASED,        // stopped by error
  output ccrz_pkg::ccrz_flow_s            FLOW           // flow control cfg
);

  localparam int TW = ccrz_pkg::TMR_W;

  generate
    if (REC_CYC < 1 || REC_CYC >= 2**TW || DIS_CYC < 1 || DIS_CYC >= 2**TW
        || SRST_CYC < 1 || SRST_CYC >= 2**TW) begin : g_chk
      $error("ccrz_top: cycle count does not fit the timer");
    end
  endgenerate

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic [1:0] sel_reg(input logic [ccrz_pkg::ADDR_W-1:0] a);
    logic [1:0]                  s;
    logic [ccrz_pkg::ADDR_W-3:0] w;
    s = ccrz_pkg::SEL_NONE;
    w = a[ccrz_pkg::ADDR_W-1:2];
    if (w == ccrz_pkg::OFF_CTL0[ccrz_pkg::ADDR_W-1:2]) begin
      s = ccrz_pkg::SEL_CTL;
    end else if (w == ccrz_pkg::OFF_AUX[ccrz_pkg::ADDR_W-1:2]) begin
      s = ccrz_pkg::SEL_AUX;
    end else if (w == ccrz_pkg::OFF_STS[ccrz_pkg::ADDR_W-1:2]) begin
      s = ccrz_pkg::SEL_STS;
    end
    return s;
  endfunction

  ccrz_pkg::ccrz_ctl_s   ctl_q;
  ccrz_pkg::ccrz_ctl_s   ctl_d;
  ccrz_pkg::ccrz_state_e state_q;
  ccrz_pkg::ccrz_state_e state_d;
  logic                  smod_q;
  logic                  err_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;
  logic                  start_q;
  logic                  abort_q;
  logic                  halt_q;
  logic                  srclr_q;
  logic                  start_d;
  logic                  abort_d;
  logic                  tmr_zero;
  logic                  tmr_load;
  logic [TW-1:0]         tmr_val;

  wire             wr_fire  = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_q;
  wire             rd_fire  = S_AXI_ARVALID & ~rvalid_q;
  wire [1:0]       wr_sel   = sel_reg(S_AXI_AWADDR);
  wire [1:0]       rd_sel   = sel_reg(S_AXI_ARADDR);
  wire             wr_ctl   = wr_fire & (wr_sel == ccrz_pkg::SEL_CTL)
                              & S_AXI_WSTRB[1];
  wire             wr_aux   = wr_fire & (wr_sel == ccrz_pkg::SEL_AUX)
                              & S_AXI_WSTRB[0];
  wire [15:0]      wdat     = S_AXI_WDATA[15:0];
  wire             prot_ok  = ~ctl_q.en | smod_q;
  wire             halt_frz = FREEZE_MODE & ctl_q.frz;
  wire             halt_wai = WAIT_MODE & ctl_q.wai;
  wire             halt_req = halt_frz | halt_wai;
  wire             srst_go  = (state_d == ccrz_pkg::S_SRST)
                              & (state_q != ccrz_pkg::S_SRST);
  wire             srst_end = (state_q == ccrz_pkg::S_SRST) & tmr_zero;
  wire [ccrz_pkg::STS_W-1:0] sts_word = {
    state_q == ccrz_pkg::S_RECOVER, state_q == ccrz_pkg::S_DRAIN,
    state_q == ccrz_pkg::S_SRST,    err_q,
    halt_q,                         state_q == ccrz_pkg::S_BUSY,
    state_q == ccrz_pkg::S_READY,   ctl_q.en};
  wire [31:0]      rd_mux   =
    (rd_sel == ccrz_pkg::SEL_CTL) ? {16'h0000, ctl_q} :
    (rd_sel == ccrz_pkg::SEL_AUX) ? {31'h00000000, smod_q} :
    (rd_sel == ccrz_pkg::SEL_STS) ? {{(32-ccrz_pkg::STS_W){1'b0}}, sts_word} :
                                    32'h00000000;

  // ****************************************************************
  // control register next value
  // ****************************************************************
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d.en  = wdat[ccrz_pkg::EN_BIT];
      ctl_d.frz = wdat[ccrz_pkg::FRZ_BIT];
      ctl_d.wai = wdat[ccrz_pkg::WAI_BIT];
      if (!ctl_q.sr && wdat[ccrz_pkg::SR_BIT]) begin
        ctl_d.sr = 1'b1;
      end
      if (prot_ok) begin
        ctl_d.acc  = wdat[ccrz_pkg::ACC_LSB +: 2];
        ctl_d.str  = wdat[ccrz_pkg::STR_BIT];
        ctl_d.mode = wdat[ccrz_pkg::MOD_BIT];
      end
    end
    if (srst_end) begin
      ctl_d.sr = 1'b0;
    end
    ctl_d.rsvd = 8'h00;
  end

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    case (state_q)
      ccrz_pkg::S_OFF: begin
        if (ctl_q.sr) begin
          state_d = ccrz_pkg::S_SRST;
        end else if (err_q) begin
          state_d = ccrz_pkg::S_ERROR;
        end else if (ctl_q.en) begin
          state_d = ccrz_pkg::S_RECOVER;
        end
      end
      ccrz_pkg::S_RECOVER, ccrz_pkg::S_READY, ccrz_pkg::S_BUSY: begin
        if (ctl_q.sr) begin
          state_d = ccrz_pkg::S_SRST;
          abort_d = (state_q == ccrz_pkg::S_BUSY);
        end else if (err_q) begin
          state_d = ccrz_pkg::S_ERROR;
          abort_d = (state_q == ccrz_pkg::S_BUSY);
        end else if (!ctl_q.en) begin
          state_d = ccrz_pkg::S_DRAIN;
          abort_d = (state_q == ccrz_pkg::S_BUSY);
        end else if (state_q == ccrz_pkg::S_RECOVER) begin
          if (tmr_zero) begin
            state_d = ccrz_pkg::S_READY;
          end
        end else if (state_q == ccrz_pkg::S_READY) begin
          // halt only bites here, so halt never cuts a running conversion short
          if (TRIG && !halt_req) begin
            state_d = ccrz_pkg::S_BUSY;
            start_d = 1'b1;
          end
        end else if (CONV_DONE) begin
          state_d = ccrz_pkg::S_READY;
        end
      end
      ccrz_pkg::S_DRAIN: begin
        if (ctl_q.sr) begin
          state_d = ccrz_pkg::S_SRST;
        end else if (tmr_zero) begin
          state_d = ccrz_pkg::S_OFF;
        end
      end
      ccrz_pkg::S_SRST: begin
        if (tmr_zero) begin
          state_d = ccrz_pkg::S_OFF;
        end
      end
      ccrz_pkg::S_ERROR: begin
        if (ctl_q.sr) begin
          state_d = ccrz_pkg::S_SRST;
        end
      end
      default: begin
        state_d = ccrz_pkg::S_OFF;
      end
    endcase
  end

  // a wait is loaded once, on entry to the state that needs it
  assign tmr_load = (state_d != state_q) &
                    ((state_d == ccrz_pkg::S_RECOVER) |
                     (state_d == ccrz_pkg::S_DRAIN) |
                     (state_d == ccrz_pkg::S_SRST));
  assign tmr_val  = (state_d == ccrz_pkg::S_RECOVER) ? TW'(REC_CYC) :
                    (state_d == ccrz_pkg::S_DRAIN)   ? TW'(DIS_CYC) :
                                                       TW'(SRST_CYC);

  ccrz_timer #(
    .W     (TW)
  ) u_timer (
    .clk   (MCLK),
    .rst_n (RST_N),
    .load  (tmr_load),
    .val   (tmr_val),
    .zero  (tmr_zero)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_q   <= ccrz_pkg::CTL0_RST;
      smod_q  <= 1'b0;
      err_q   <= 1'b0;
      state_q <= ccrz_pkg::S_OFF;
      start_q <= 1'b0;
      abort_q <= 1'b0;
      halt_q  <= 1'b0;
      srclr_q <= 1'b0;
    end else begin
      ctl_q   <= ctl_d;
      smod_q  <= wr_aux ? S_AXI_WDATA[ccrz_pkg::SMOD_BIT] : smod_q;
      err_q   <= SEVERE_ERR | (err_q & ~srst_go);
      state_q <= state_d;
      start_q <= start_d;
      abort_q <= abort_d;
      halt_q  <= halt_req & (state_q == ccrz_pkg::S_READY);
      srclr_q <= srst_go;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      bvalid_q <= 1'b0;
      bresp_q  <= ccrz_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_sel == ccrz_pkg::SEL_NONE) ? ccrz_pkg::RESP_SLVERR
                                                 : ccrz_pkg::RESP_OKAY;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= ccrz_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= (rd_sel == ccrz_pkg::SEL_NONE) ? ccrz_pkg::RESP_SLVERR
                                                 : ccrz_pkg::RESP_OKAY;
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign S_AXI_AWREADY   = wr_fire;
  assign S_AXI_WREADY    = wr_fire;
  assign S_AXI_BVALID    = bvalid_q;
  assign S_AXI_BRESP     = bresp_q;
  assign S_AXI_ARREADY   = rd_fire;
  assign S_AXI_RVALID    = rvalid_q;
  assign S_AXI_RDATA     = rdata_q;
  assign S_AXI_RRESP     = rresp_q;
  assign ANALOG_EN       = ctl_q.en;
  assign CONV_START      = start_q;
  assign CONV_ABORT      = abort_q;
  assign CONV_HALT       = halt_q;
  assign SRST_CLEAR      = srclr_q;
  assign CEASED          = err_q;
  assign FLOW            = {ctl_q.acc[0], ctl_q.acc[1],
                            ctl_q.mode, ctl_q.str};

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_sr_sticky: assert property (@(posedge MCLK) disable iff (!RST_N)
    ctl_q.sr && !srst_end |=> ctl_q.sr)
    else $error("soft reset bit dropped early");

  a_abort_off: assert property (@(posedge MCLK) disable iff (!RST_N)
    state_q == ccrz_pkg::S_BUSY && !ctl_q.en && !ctl_q.sr && !err_q
    |=> abort_q && state_q == ccrz_pkg::S_DRAIN)
    else $error("disable did not abort conversion");

  a_drain_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    state_q == ccrz_pkg::S_DRAIN && !tmr_zero
    |=> state_q != ccrz_pkg::S_RECOVER && state_q != ccrz_pkg::S_OFF)
    else $error("re-enabled before drain finished");

  a_start_ready: assert property (@(posedge MCLK) disable iff (!RST_N)
    start_q |-> $past(state_q) == ccrz_pkg::S_READY && $past(TRIG))
    else $error("start outside ready state");

  a_srst_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(ctl_q.sr) |-> ##[1:2] srclr_q)
    else $error("soft reset clear pulse missing");

  a_srst_idle: assert property (@(posedge MCLK) disable iff (!RST_N)
    srst_end |=> state_q == ccrz_pkg::S_OFF && !ctl_q.sr)
    else $error("soft reset did not return to idle");

  a_err_cease: assert property (@(posedge MCLK) disable iff (!RST_N)
    err_q |=> !start_q)
    else $error("conversion started after severe error");

  a_frz_halt: assert property (@(posedge MCLK) disable iff (!RST_N)
    halt_frz && state_q == ccrz_pkg::S_READY |=> !start_q && halt_q)
    else $error("freeze halt not honoured");

  a_wai_halt: assert property (@(posedge MCLK) disable iff (!RST_N)
    halt_wai && state_q == ccrz_pkg::S_READY |=> !start_q && halt_q)
    else $error("wait halt not honoured");

  a_any_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_ctl |=> ctl_q.en == $past(wdat[ccrz_pkg::EN_BIT])
           && ctl_q.frz == $past(wdat[ccrz_pkg::FRZ_BIT]))
    else $error("anytime bits not written");

  a_prot_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_ctl && ctl_q.en && !smod_q
    |=> ctl_q.acc == $past(ctl_q.acc) && ctl_q.mode == $past(ctl_q.mode))
    else $error("protected field changed while enabled");

  a_path_code: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_ctl && prot_ok
    |=> FLOW.bus_path == $past(wdat[ccrz_pkg::ACC_LSB + 1])
     && FLOW.int_path == $past(wdat[ccrz_pkg::ACC_LSB]))
    else $error("access path decode wrong");

endmodule

`default_nettype wire

// [verification/ccrz_tb.sv]
// Purpose: self-checking bench for converter control register zero
// Assumes: AXI4-Lite master tasks, REC count shorter and DIS/SRST counts longer than the defaults
// Notes:   register model kept in ctl_m/aux_m, ctl_m compared at every chk_ctl read
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
  bad_count++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end

module converter_control_register_zero_tb;
  localparam int REC = 3;
  localparam int DIS = 8;
  logic        mclk = 0, rst_n = 0, aux_m = 0;
  logic [3:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        trig = 0, done = 0, frz_md = 0, wai_md = 0, sev = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        en, start, abort, halt, srclr, ceased;
  logic [15:0] ctl_m = 0;
  ccrz_pkg::ccrz_flow_s flow;
  int          bad_count = 0, n_checks = 0, n_start = 0, n_abort = 0;
  int          n_clr = 0, n, c;

  ccrz_top #(.REC_CYC(REC), .DIS_CYC(DIS), .SRST_CYC(8)) DUT (
    .MCLK(mclk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .TRIG(trig), .CONV_DONE(done),
    .FREEZE_MODE(frz_md), .WAIT_MODE(wai_md), .SEVERE_ERR(sev),
    .ANALOG_EN(en), .CONV_START(start), .CONV_ABORT(abort),
    .CONV_HALT(halt), .SRST_CLEAR(srclr), .CEASED(ceased), .FLOW(flow));

  initial begin
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (start === 1'b1) n_start++;
    if (abort === 1'b1) n_abort++;
    if (srclr === 1'b1) n_clr++;
  end

  // ****************************************************************
  // bus tasks and register model
  // ****************************************************************
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] ex;
    ex = (a[3:2] == 2'h3) ? ccrz_pkg::RESP_SLVERR : ccrz_pkg::RESP_OKAY;
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do @(posedge mclk); while (awready !== 1'b1);
    awvalid <= 0; wvalid <= 0;
    if (a == 4'h4) aux_m = d[0];
    if (a == 4'h0) begin
      if (!ctl_m[15] || aux_m) ctl_m[11:8] = d[11:8];
      ctl_m[15:12] = {d[15], ctl_m[14] | d[14], d[13:12]};
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 0;
    `CHK("bresp", ex, bresp)
    // one idle edge, so a next call never re-raises bready in this step
    @(posedge mclk);
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    logic [1:0] ex;
    ex = (a[3:2] == 2'h3) ? ccrz_pkg::RESP_SLVERR : ccrz_pkg::RESP_OKAY;
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 0;
    d = rdata;
    `CHK("rresp", ex, rresp)
    @(posedge mclk);
  endtask

  task automatic chk_ctl();
    axr(4'h0, rd);
    `CHK("ctl", {16'h0000, ctl_m}, rd)
    `CHK("flow", {ctl_m[10], ctl_m[11], ctl_m[8], ctl_m[9]}, flow)
    `CHK("enable", ctl_m[15], en)
  endtask

  task automatic wait_start(output int k);
    k = 0;
    while (start !== 1'b1 && k < 80) begin
      @(posedge mclk);
      k++;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    void'($urandom(10034));
    repeat (16) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    chk_ctl();
    for (int i = 0; i < 4; i++) begin
      axw(4'h0, (i << 10) | 32'h0100);
      chk_ctl();
    end
    trig <= 1;
    axw(4'h0, 32'h8F00);
    wait_start(n);
    `CHK("recovery", 1'b1, n >= REC && n <= REC + 3)
    trig <= 0;
    axw(4'h0, 32'h0000);
    chk_ctl();
    `CHK("abort", 1, n_abort)
    trig <= 1;
    axw(4'h0, 32'h8000);
    wait_start(n);
    `CHK("reenable", 1'b1, n >= REC + DIS - 2)
    trig <= 0; done <= 1;
    @(posedge mclk);
    done <= 0; frz_md <= 1;
    axw(4'h0, 32'hA000);
    c = n_start; trig <= 1;
    repeat (6) @(posedge mclk);
    `CHK("frz_halt", 1'b1, halt)
    // wait mode on before the bit swap, so no unhalted gap lets trig in
    wai_md <= 1;
    axw(4'h0, 32'h9000);
    frz_md <= 0;
    repeat (4) @(posedge mclk);
    `CHK("wai_halt", 1'b1, halt)
    `CHK("no_start", c, n_start)
    wai_md <= 0;
    repeat (6) @(posedge mclk);
    `CHK("resume", c + 1, n_start)
    trig <= 0; sev <= 1;
    @(posedge mclk);
    sev <= 0;
    repeat (2) @(posedge mclk);
    `CHK("ceased", 1'b1, ceased)
    c = n_clr;
    axw(4'h0, {16'h0000, ctl_m | 16'h4000});
    axw(4'h0, {16'h0000, ctl_m & 16'hBFFF});
    chk_ctl();
    repeat (14) @(posedge mclk);
    ctl_m[14] = 0;
    chk_ctl();
    `CHK("ceased_clr", 1'b0, ceased)
    `CHK("clear_pulse", c + 1, n_clr)
    for (int i = 0; i < 8; i++) begin
      axw(4'h4, $urandom & 32'h1);
      axw(4'h0, $urandom & 32'hBF00);
      chk_ctl();
    end
    axw(4'hC, 32'hFFFF);
    axr(4'hC, rd);
    `CHK("unmapped", 32'h0, rd)
    complete_run();
  end

  initial begin
    #(100 * 4000);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
